// ===== btb_pkg.sv
`default_nettype none
package btb_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int PC_W = 17;
   localparam int ADDR_W = 16;

   // ----------------------------------------------------------------
   // Instruction lengths and cycle counts
   // ----------------------------------------------------------------
   localparam logic [2:0] LEN_SHORT = 3'h3;
   localparam logic [2:0] LEN_MID = 3'h4;
   localparam logic [2:0] LEN_JUMP = 3'h2;
   localparam logic [1:0] CYC_SHORT = 2'h2;
   localparam logic [1:0] CYC_MID = 2'h3;
   localparam logic [1:0] CYC_JUMP = 2'h2;

   // ----------------------------------------------------------------
   // Opcode fields
   // ----------------------------------------------------------------
   localparam logic [4:0] PAT_LOW_PAGE = 5'h01;  // First byte 08H..0FH
   localparam logic [4:0] PAT_FE_PAGE = 5'h03;   // First byte 18H..1FH
   localparam logic [7:0] PAGE_FE = 8'hfe;
   localparam logic [7:0] PAGE_LOW = 8'h00;
   localparam logic [7:0] OP_MID = 8'he7;
   localparam logic [7:0] OP_CLEAR = 8'ha7;
   localparam logic [2:0] PAT_JUMP_HI = 3'h3;    // Bits 7..5 of 68H..7FH
   localparam int BIT_LSB = 0;                   // Bit select in short opcode
   localparam int MID_BIT_LSB = 5;               // Bit select in mid third byte
   localparam int MID_HI_W = 5;                  // Upper address bits 12..8

   // ----------------------------------------------------------------
   // Reset PC and sequencer count values
   // ----------------------------------------------------------------
   localparam logic [PC_W-1:0] PC_RST = 17'h00000;
   localparam logic [1:0] CNT_FIRST = 2'h1;
   localparam logic [1:0] CNT_DATA = 2'h2;

   typedef enum logic [1:0] {OPK_NONE, OPK_BIT, OPK_CLEAR, OPK_JUMP} btb_op_e;
   typedef enum logic {ST_IDLE, ST_EXEC} btb_state_e;
endpackage : btb_pkg
`default_nettype wire

// ===== btb_dec_if.sv
`default_nettype none
interface btb_dec_if;
   logic [31:0] instr;
   btb_pkg::btb_op_e op;
   logic [2:0] len;
   logic [1:0] cyc;
   logic [btb_pkg::ADDR_W-1:0] addr;
   logic [2:0] bit_sel;
   logic [btb_pkg::PC_W-1:0] offset;
   modport dec (input instr, output op, len, cyc, addr, bit_sel, offset);
   modport exe (output instr, input op, len, cyc, addr, bit_sel, offset);
endinterface : btb_dec_if
`default_nettype wire

// ===== btb_decoder.sv
`default_nettype none
module btb_decoder (
   btb_dec_if.dec dif
);
   logic [7:0] b0;
   logic [7:0] b1;
   logic [7:0] b2;
   assign b0 = dif.instr[7:0];
   assign b1 = dif.instr[15:8];
   assign b2 = dif.instr[23:16];

   always_comb begin
      dif.op = btb_pkg::OPK_NONE;
      dif.len = btb_pkg::LEN_SHORT;
      dif.cyc = btb_pkg::CYC_SHORT;
      dif.addr = '0;
      dif.bit_sel = b0[btb_pkg::BIT_LSB +: 3];
      // Offsets are signed so backward branches work
      dif.offset = {{(btb_pkg::PC_W-8){b2[7]}}, b2};
      if (b0[7:3] == btb_pkg::PAT_LOW_PAGE || b0[7:3] == btb_pkg::PAT_FE_PAGE) begin
         // Short form: one page, the page chosen by opcode bit 4
         dif.op = btb_pkg::OPK_BIT;
         dif.addr = {(b0[4] ? btb_pkg::PAGE_FE : btb_pkg::PAGE_LOW), b1};
      end else if (b0 == btb_pkg::OP_MID || b0 == btb_pkg::OP_CLEAR) begin
         dif.op = (b0 == btb_pkg::OP_CLEAR) ? btb_pkg::OPK_CLEAR : btb_pkg::OPK_BIT;
         dif.len = btb_pkg::LEN_MID;
         dif.cyc = btb_pkg::CYC_MID;
         dif.bit_sel = b2[btb_pkg::MID_BIT_LSB +: 3];
         dif.addr = {3'h0, b2[btb_pkg::MID_HI_W-1:0], b1};
         dif.offset = {{(btb_pkg::PC_W-8){dif.instr[31]}}, dif.instr[31:24]};
      end else if (b0[7:5] == btb_pkg::PAT_JUMP_HI && b0[3]) begin
         dif.op = btb_pkg::OPK_JUMP;
         dif.len = btb_pkg::LEN_JUMP;
         dif.cyc = btb_pkg::CYC_JUMP;
         dif.offset = {{(btb_pkg::PC_W-12){b0[4]}}, b0[4], b0[2:0], b1};
      end
   end
endmodule : btb_decoder
`default_nettype wire

// ===== btb_exec.sv
// Summary of operation
// - Set bit branches PC+length+offset, else PC+length
// - Three-bit field picks tested bit
// - Short form 3 bytes/2 cycles; mid 4/3
// - Short opcode is bit merged with 08H/18H
// - E7H, address low, bit+address high, offset
// - Mid form always 4 bytes, 3 cycles
// - Mid forms address 13-bit data memory
// - A7H clears set bit, then branches
// - Jump is 2 bytes, 12-bit split offset
// - Jump loads PC+2+offset unconditionally
`default_nettype none
module btb_exec (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic instr_valid,
   output logic instr_ready,
   input wire logic [31:0] instr_word,
   input wire logic [btb_pkg::PC_W-1:0] instr_pc,
   output logic mem_rd,
   output logic mem_wr,
   output logic [btb_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   output logic [7:0] mem_wdata,
   output logic done,
   output logic taken,
   output logic bad_opcode,
   output logic [btb_pkg::PC_W-1:0] next_pc
);
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   btb_dec_if dif ();
   assign dif.instr = instr_word;
   btb_decoder u_dec (
      .dif (dif)
   );

   // ----------------------------------------------------------------
   // Sequencer state
   // ----------------------------------------------------------------
   btb_pkg::btb_state_e state, next_state;
   btb_pkg::btb_op_e op, next_op;
   logic [1:0] cnt, next_cnt;
   logic [1:0] cyc_tot, next_cyc_tot;
   logic [2:0] len, next_len;
   logic [2:0] bit_sel, next_bit_sel;
   logic [btb_pkg::PC_W-1:0] off, next_off;
   logic [btb_pkg::PC_W-1:0] start_pc, next_start_pc;
   logic [btb_pkg::ADDR_W-1:0] next_mem_addr;
   logic [7:0] held, next_held;
   logic [7:0] next_mem_wdata;
   logic next_done, next_taken, next_bad_opcode;
   logic [btb_pkg::PC_W-1:0] next_next_pc;
   logic bit_val;
   logic accept;

   assign instr_ready = (state == btb_pkg::ST_IDLE);
   assign accept = instr_valid && instr_ready;
   assign mem_rd = (state == btb_pkg::ST_EXEC) && (cnt == btb_pkg::CNT_FIRST)
                   && (op != btb_pkg::OPK_JUMP);
   // Write back only on the last cycle, and only if the bit was found set
   assign mem_wr = (state == btb_pkg::ST_EXEC) && (cnt == btb_pkg::CYC_MID)
                   && (op == btb_pkg::OPK_CLEAR) && held[bit_sel];

   // Two-cycle bit tests use the byte as it arrives (a jump tests nothing); three-cycle forms use the copy
   always_comb begin
      if (op == btb_pkg::OPK_JUMP) begin
         bit_val = 1'b1;
      end else if (cnt == btb_pkg::CNT_DATA) begin
         bit_val = mem_rdata[bit_sel];
      end else begin
         bit_val = held[bit_sel];
      end
   end

   always_comb begin
      next_state = state;
      next_op = op;
      next_cnt = cnt;
      next_cyc_tot = cyc_tot;
      next_len = len;
      next_bit_sel = bit_sel;
      next_off = off;
      next_start_pc = start_pc;
      next_mem_addr = mem_addr;
      next_held = held;
      next_mem_wdata = mem_wdata;
      next_done = 1'b0;
      next_taken = taken;
      next_bad_opcode = 1'b0;
      next_next_pc = next_pc;
      unique case (state)
         btb_pkg::ST_IDLE: begin
            if (accept) begin
               if (dif.op == btb_pkg::OPK_NONE) begin
                  // Not ours: answer at once and leave the PC alone
                  next_bad_opcode = 1'b1;
                  next_done = 1'b1;
                  next_taken = 1'b0;
                  next_next_pc = instr_pc;
               end else begin
                  next_state = btb_pkg::ST_EXEC;
                  next_op = dif.op;
                  next_cnt = btb_pkg::CNT_FIRST;
                  next_cyc_tot = dif.cyc;
                  next_len = dif.len;
                  next_bit_sel = dif.bit_sel;
                  next_off = dif.offset;
                  next_start_pc = instr_pc;
                  next_mem_addr = dif.addr;
               end
            end
         end
         btb_pkg::ST_EXEC: begin
            next_cnt = cnt + 2'h1;
            if (cnt == btb_pkg::CNT_DATA) begin
               next_held = mem_rdata;
               next_mem_wdata = mem_rdata & ~(8'h01 << bit_sel);
            end
            if (cnt == cyc_tot) begin
               next_state = btb_pkg::ST_IDLE;
               next_done = 1'b1;
               next_taken = bit_val;
               // Offset is already sign-extended, so the sum wraps correctly
               next_next_pc = start_pc + {{(btb_pkg::PC_W-3){1'b0}}, len}
                              + (bit_val ? off : '0);
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= btb_pkg::ST_IDLE;
         op <= btb_pkg::OPK_NONE;
         cnt <= '0;
         cyc_tot <= btb_pkg::CYC_SHORT;
         len <= '0;
         bit_sel <= '0;
         off <= '0;
         start_pc <= btb_pkg::PC_RST;
         mem_addr <= '0;
         held <= '0;
         mem_wdata <= '0;
         done <= 1'b0;
         taken <= 1'b0;
         bad_opcode <= 1'b0;
         next_pc <= btb_pkg::PC_RST;
      end else begin
         state <= next_state;
         op <= next_op;
         cnt <= next_cnt;
         cyc_tot <= next_cyc_tot;
         len <= next_len;
         bit_sel <= next_bit_sel;
         off <= next_off;
         start_pc <= next_start_pc;
         mem_addr <= next_mem_addr;
         held <= next_held;
         mem_wdata <= next_mem_wdata;
         done <= next_done;
         taken <= next_taken;
         bad_opcode <= next_bad_opcode;
         next_pc <= next_next_pc;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_acc_short;
      accept && dif.op == btb_pkg::OPK_BIT && dif.cyc == btb_pkg::CYC_SHORT;
   endsequence
   sequence s_acc_mid;
      accept && (dif.op == btb_pkg::OPK_BIT || dif.op == btb_pkg::OPK_CLEAR);
   endsequence
   sequence s_acc_jump;
      accept && dif.op == btb_pkg::OPK_JUMP;
   endsequence

   // Done is registered, so it shows one cycle after the last execution cycle; in the
   // acceptance cycle it may still be high from the previous instruction
   sequence s_short_run;
      ##1 !done [*2] ##1 done;
   endsequence
   sequence s_mid_run;
      ##1 !done [*3] ##1 done;
   endsequence

   a_short_done_time: assert property (s_acc_short |-> s_short_run)
      else $error("short bit test did not finish in two cycles");
   a_mid_done_time: assert property (s_acc_mid and (dif.cyc == btb_pkg::CYC_MID)
         |-> s_mid_run)
      else $error("mid bit test did not finish in three cycles");
   a_jump_target: assert property (s_acc_jump |-> ##3 (done && taken && next_pc ==
         $past(instr_pc, 3) + 17'h00002 + {{5{$past(instr_word[4], 3)}},
         $past(instr_word[4], 3), $past(instr_word[2:0], 3), $past(instr_word[15:8], 3)}))
      else $error("relative jump target wrong");
   a_not_taken: assert property (done && !taken && !bad_opcode
         |-> next_pc == start_pc + {14'h0000, len})
      else $error("untaken branch did not advance by length");
   a_taken_pc: assert property (done && taken && !bad_opcode
         |-> next_pc == start_pc + {14'h0000, len} + off)
      else $error("taken branch target wrong");
   a_short_test: assert property (s_acc_short ##1 mem_rd
         |-> ##2 (taken == $past(mem_rdata[bit_sel])))
      else $error("short form tested the wrong bit");
   a_mid_addr: assert property (s_acc_mid and (dif.len == btb_pkg::LEN_MID) |-> ##1
         (mem_rd && mem_addr == {3'h0, $past(instr_word[20:16]), $past(instr_word[15:8])}))
      else $error("mid form memory address wrong");
   a_short_decode: assert property (accept && (instr_word[7:3] == btb_pkg::PAT_LOW_PAGE
         || instr_word[7:3] == btb_pkg::PAT_FE_PAGE) |-> dif.len == btb_pkg::LEN_SHORT
         && dif.addr[15:8] == (instr_word[4] ? btb_pkg::PAGE_FE : btb_pkg::PAGE_LOW))
      else $error("short form decode wrong");
   a_mid_decode: assert property (accept && instr_word[7:0] == btb_pkg::OP_MID
         |-> dif.op == btb_pkg::OPK_BIT && dif.len == btb_pkg::LEN_MID
         && dif.bit_sel == instr_word[23:21])
      else $error("mid form decode wrong");
   a_clear_write: assert property (mem_wr |-> mem_wdata[bit_sel] == 1'b0
         && done == 1'b0 ##1 (done && taken))
      else $error("clear form write back wrong");
   a_clear_keeps: assert property (done && !taken && op == btb_pkg::OPK_CLEAR
         |-> !$past(mem_wr))
      else $error("clear form wrote memory on clear bit");
   a_jump_decode: assert property (s_acc_jump |-> dif.len == btb_pkg::LEN_JUMP
         && dif.offset[16:11] == {6{instr_word[4]}})
      else $error("jump decode or sign extension wrong");
endmodule : btb_exec
`default_nettype wire

// ===== tb_bit_test_branch_exec.sv
`default_nettype none
module tb_bit_test_branch_exec;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Expected outcome of one instruction
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [16:0] npc;
      logic tk;
      logic bad;
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wd;
      logic [2:0] lat;
   } btb_tb_exp_s;
   logic ref_clk, srst, instr_valid, instr_ready, mem_rd, mem_wr, done, taken, bad_opcode;
   logic [31:0] instr_word;
   logic [btb_pkg::PC_W-1:0] instr_pc, next_pc;
   logic [btb_pkg::ADDR_W-1:0] mem_addr, rd_addr, wr_addr;
   logic [7:0] mem_rdata = 8'h00;
   logic [7:0] mem_wdata, rd_byte, wr_data, rd_cnt, wr_cnt;
   int err_total = 0;
   int check_count = 0;
   int seed;
`define BTB_CHK(nm, ex, got) \
   begin \
      check_count++; \
      if ((got) !== (ex)) begin \
         err_total++; \
         $display("mismatch %s expected %h seen %h", nm, ex, got); \
      end \
   end
   btb_exec u_dut (.ref_clk(ref_clk), .srst(srst), .instr_valid(instr_valid),
      .instr_ready(instr_ready), .instr_word(instr_word), .instr_pc(instr_pc),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
      .mem_wdata(mem_wdata), .done(done), .taken(taken), .bad_opcode(bad_opcode),
      .next_pc(next_pc));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // ----------------------------------------------------------------
   // Memory side: one cycle read latency, stale data never repeated
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      mem_rdata <= mem_rd ? rd_byte : ~mem_rdata;
      if (mem_rd) begin
         rd_cnt <= rd_cnt + 8'h01;
         rd_addr <= mem_addr;
      end
      if (mem_wr) begin
         wr_cnt <= wr_cnt + 8'h01;
         wr_addr <= mem_addr;
         wr_data <= mem_wdata;
      end
   end
   function automatic btb_tb_exp_s predict(input logic [31:0] w, input logic [16:0] pc,
                                           input logic [7:0] d);
      btb_tb_exp_s e;
      logic [7:0] op;
      logic [16:0] off;
      logic [2:0] b;
      logic [2:0] len;
      op = w[7:0];
      e = '0;
      e.npc = pc;
      e.bad = 1'b1;
      // An unknown opcode is answered on the edge right after it is taken
      e.lat = 3'h1;
      len = 3'h0;
      b = 3'h0;
      off = 17'h00000;
      if (op[7:5] == 3'h0 && op[3]) begin
         b = op[2:0];
         e.addr = {op[4] ? 8'hfe : 8'h00, w[15:8]};
         off = {{9{w[23]}}, w[23:16]};
         len = 3'h3;
      end else if (op == 8'he7 || op == 8'ha7) begin
         b = w[23:21];
         e.addr = {3'h0, w[20:8]};
         off = {{9{w[31]}}, w[31:24]};
         len = 3'h4;
      end
      if (len != 3'h0) begin
         // Done shows one edge after the last execution cycle
         e.bad = 1'b0;
         e.rd = 1'b1;
         e.lat = len;
         e.tk = d[b];
         e.wr = e.tk && op == 8'ha7;
         e.wd = d & ~(8'h01 << b);
         e.npc = pc + {14'h0000, len} + (e.tk ? off : 17'h00000);
      end else if (op[7:5] == 3'h3 && op[3]) begin
         e.bad = 1'b0;
         e.tk = 1'b1;
         e.lat = 3'h3;
         e.npc = pc + 17'h00002 + {{5{op[4]}}, op[4], op[2:0], w[15:8]};
      end
      return e;
   endfunction : predict
   task automatic print_verdict();
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict
   task automatic run_op(input logic [31:0] w, input logic [16:0] pc, input logic [7:0] d);
      btb_tb_exp_s e;
      int n;
      e = predict(w, pc, d);
      rd_byte = d;
      rd_cnt <= 8'h00;
      wr_cnt <= 8'h00;
      instr_valid <= 1'b1;
      instr_word <= w;
      instr_pc <= pc;
      n = 0;
      @(posedge ref_clk);
      while (instr_ready !== 1'b1 && n < 10) begin
         @(posedge ref_clk);
         n++;
      end
      if (instr_ready !== 1'b1) begin
         `BTB_CHK("ready_timeout", 1'b1, instr_ready);
         print_verdict();
      end
      // Scramble the word so a design that fails to latch it is caught
      instr_valid <= 1'b0;
      instr_word <= ~w;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
         // Only an unknown opcode leaves the port ready while it is answered
         if (n == 1) `BTB_CHK("ready_busy", e.bad, instr_ready);
      end while (done !== 1'b1 && n < 10);
      if (done !== 1'b1) begin
         `BTB_CHK("done_timeout", 1'b1, done);
         print_verdict();
      end
      `BTB_CHK("latency", {1'b0, e.lat}, n[3:0]);
      `BTB_CHK("next_pc", e.npc, next_pc);
      `BTB_CHK("taken", e.tk, taken);
      `BTB_CHK("bad_opcode", e.bad, bad_opcode);
      `BTB_CHK("reads", {7'h00, e.rd}, rd_cnt);
      if (e.rd) `BTB_CHK("read_addr", e.addr, rd_addr);
      `BTB_CHK("writes", {7'h00, e.wr}, wr_cnt);
      if (e.wr) `BTB_CHK("write", {e.addr, e.wd}, {wr_addr, wr_data});
   endtask : run_op
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   logic [31:0] dw [11] = '{32'h003f1008, 32'h003f0018, 32'h3f0010e7, 32'h3f0200e7,
      32'h3f0010a7, 32'h3f0200a7, 32'h00003f68, 32'h0000f97f, 32'h80ffffa7, 32'h000000c0,
      32'h0080ff1f};
   logic [16:0] dp [11] = '{17'h00f1d, 17'h00f1d, 17'h00f1c, 17'h00f1c, 17'h00f1c,
      17'h00f1c, 17'h00f1e, 17'h01f13, 17'h00010, 17'h12345, 17'h1ffff};
   logic [7:0] dd [11] = '{8'h01, 8'h80, 8'h01, 8'h80, 8'h03, 8'h80, 8'h00, 8'h00, 8'h80,
      8'hff, 8'h80};
   initial begin
      logic [31:0] w;
      logic [31:0] r;
      seed = 66;
      srst = 1'b1;
      instr_valid = 1'b0;
      instr_word = 32'h00000000;
      instr_pc = 17'h00000;
      rd_byte = 8'h00;
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      `BTB_CHK("reset_state", 5'h10, {instr_ready, done, taken, mem_rd, mem_wr});
      `BTB_CHK("reset_pc", 17'h00000, next_pc);
      for (int i = 0; i < 11; i++) run_op(dw[i], dp[i], dd[i]);
      // Reset in mid-instruction must abandon it
      instr_valid <= 1'b1;
      instr_word <= 32'h3f0010e7;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      srst <= 1'b1;
      @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      `BTB_CHK("abort_state", 3'h4, {instr_ready, done, taken});
      for (int i = 0; i < 60; i++) begin
         w = $random(seed);
         r = $random(seed);
         case (r[2:0])
            3'h0: w[7:3] = 5'h01;
            3'h1: w[7:3] = 5'h03;
            3'h2: w[7:0] = 8'he7;
            3'h3: w[7:0] = 8'ha7;
            3'h4: w[7:3] = {3'h3, w[4], 1'b1};
            default: ;
         endcase
         run_op(w, r[24:8], r[31:24]);
      end
      print_verdict();
   end
`undef BTB_CHK
endmodule : tb_bit_test_branch_exec
`default_nettype wire
